// file: core/remote_io_pkg.sv
// Package of constants and types for the remote input/output handshake block
package remote_io_pkg;
   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned MIN_PULSE_MS = 25;
   localparam int unsigned MIN_PULSE_CYC = (CLK_HZ / 1000) * MIN_PULSE_MS;
   localparam int unsigned SEL_SETTLE_MS = 40;
   localparam int unsigned SEL_SETTLE_CYC = (CLK_HZ / 1000) * SEL_SETTLE_MS;
   localparam int unsigned CNT_W = 20;
   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int unsigned PROG_W = 6;
   localparam int unsigned NUM_ROBOTS = 16;
   localparam int unsigned SEL_W = 5;
   localparam logic [SEL_W-1:0] SEL_ALL = 5'h00;
   localparam int unsigned NUM_CMD = 8;
   localparam logic [PROG_W-1:0] PROG_RST = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
   localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
   // Command slots in the filtered command vector
   localparam int unsigned CMD_START = 0;
   localparam int unsigned CMD_STOP = 1;
   localparam int unsigned CMD_PAUSE = 2;
   localparam int unsigned CMD_CONT = 3;
   localparam int unsigned CMD_MOTORS = 4;
   localparam int unsigned CMD_PWR_UP = 5;
   localparam int unsigned CMD_PWR_DN = 6;
   localparam int unsigned CMD_SHUTDOWN = 7;
   // ------------------------------------------------------------
   // Avalon register map (word addresses) and interrupt bits
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h2;
   localparam logic [ADDR_W-1:0] REG_IRQ_EN = 4'h3;
   localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 4'h4;
   localparam logic [ADDR_W-1:0] REG_CMD_DONE = 4'h5;
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned IRQ_ERROR = 0;
   localparam int unsigned IRQ_REJECT = 1;
   localparam int unsigned IRQ_ACCEPT = 2;
   localparam int unsigned IRQ_SHUT = 3;
   // CTRL fields
   localparam int unsigned CTRL_AUTO = 0;
   localparam int unsigned CTRL_REMOTE = 1;
   localparam int unsigned CTRL_PROGMODE = 2;
   localparam int unsigned CTRL_RIO_EN = 3;
   localparam int unsigned CTRL_ERR_SET = 4;
   localparam int unsigned CTRL_PROG_LSB = 8;
   localparam int unsigned CTRL_PROG_LD = 15;
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   localparam logic [31:0] DEAD_READ = 32'hDEADBEEF;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_ERROR = 3'b100
   } hs_state_t;
endpackage : remote_io_pkg

// file: core/pulse_qualifier.sv
// Minimum-width qualifier for one remote input line
`timescale 1ns/1ps
`default_nettype none
module pulse_qualifier #(
   parameter int unsigned MIN_CYC = remote_io_pkg::MIN_PULSE_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Line
   input wire logic level_in,
   output logic qualified
);
   import remote_io_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic hit;
   } pq_t;

   pq_t cur_ff;
   pq_t nxt_cur;
   localparam logic [CNT_W-1:0] LIMIT = CNT_W'(MIN_CYC);

   // R18: consecutive-cycle count
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.hit = 1'b0;
      if (!level_in) begin
         nxt_cur.cnt = CNT_ZERO;
      end else if (cur_ff.cnt != LIMIT) begin
         nxt_cur.cnt = cur_ff.cnt + CNT_ONE;
         // R11: one pulse after full width
         nxt_cur.hit = (cur_ff.cnt + CNT_ONE) == LIMIT;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign qualified = cur_ff.hit;
endmodule : pulse_qualifier
`default_nettype wire

// file: core/remote_io_handshake.sv
// Remote input/output handshake logic: command qualification, status combining, error latch
// Operation
// R01: Six binary-weighted lines show current or last main function number, 0 to 63.
// R02: Commands accepted only in auto+remote or program mode with remote I/O on.
// R03: External party waits 40 ms after changing robot selection before next input.
// R04: Selection code zero means all robots; one to sixteen means one robot.
// R05: All selected: motors flag set when any robot has motors energized.
// R06: All selected: home flag set only when every robot is home.
// R07: All selected: high-power flag set when any robot is in high power.
// R08: All selected: calibration flag set when any robot still needs calibration.
// R09: One selected: the four status flags follow only that robot.
// R10: One input at a time; simultaneous requests raise an error.
// R11: Inputs recognised only after staying high at least 25 ms.
// R12: Shutdown input accepted only while ready is high.
// R13: Error output stays high from the error until it is cleared.
// R14: Reset input clears the error condition and the error output.
// R15: During an error every input except reset is ignored.
// R16: Selection retained until changed; after reset all robots selected.
// R17: Command-active high while a command runs; reject flag when refused.
// R18: Width check counts consecutive asserted cycles against a configurable count.
`timescale 1ns/1ps
`default_nettype none
module remote_io_handshake
   import remote_io_pkg::*;
#(
   parameter int unsigned MIN_CYC = remote_io_pkg::MIN_PULSE_CYC,
   parameter int unsigned ROBOTS = remote_io_pkg::NUM_ROBOTS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [remote_io_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq,
   // Remote command inputs
   input wire logic program_select_in,
   input wire logic start_in,
   input wire logic stop_in,
   input wire logic pause_in,
   input wire logic continue_in,
   input wire logic energize_motors_in,
   input wire logic power_up_request_in,
   input wire logic power_down_request_in,
   input wire logic shutdown_in,
   input wire logic error_reset_in,
   input wire logic robot_select_strobe_in,
   input wire logic [remote_io_pkg::SEL_W-1:0] robot_select_code,
   // Per-robot status from the motion side
   input wire logic [ROBOTS-1:0] robot_motor_on,
   input wire logic [ROBOTS-1:0] robot_at_home,
   input wire logic [ROBOTS-1:0] robot_power_high,
   input wire logic [ROBOTS-1:0] robot_calib_missing,
   input wire logic ready_in,
   // Remote status outputs
   output logic prog_num_bit0,
   output logic prog_num_bit1,
   output logic prog_num_bit2,
   output logic prog_num_bit3,
   output logic prog_num_bit4,
   output logic prog_num_bit5,
   output logic motor_energized_flag,
   output logic home_position_flag,
   output logic high_power_flag,
   output logic calib_needed_flag,
   output logic command_active_flag,
   output logic command_reject_flag,
   output logic remote_accept_flag,
   output logic error_flag,
   output logic [remote_io_pkg::NUM_CMD-1:0] command_pulse,
   output logic shutdown_pulse
);
   import remote_io_pkg::*;

   // ------------------------------------------------------------
   // Input qualification
   // ------------------------------------------------------------
   localparam int unsigned NQ = NUM_CMD + 3;
   logic [NQ-1:0] raw_in;
   logic [NQ-1:0] qual;
   assign raw_in = {robot_select_strobe_in, error_reset_in, program_select_in,
                    shutdown_in, power_down_request_in, power_up_request_in,
                    energize_motors_in, continue_in, pause_in, stop_in, start_in};

   genvar gi;
   generate
      for (gi = 0; gi < NQ; gi++) begin : g_q
         pulse_qualifier #(.MIN_CYC(MIN_CYC)) u_q (
            .clk(clk),
            .reset_n(reset_n),
            .level_in(raw_in[gi]),
            .qualified(qual[gi])
         );
      end
   endgenerate

   logic [NUM_CMD-1:0] cmd_q;
   logic prog_q;
   logic reset_q;
   logic sel_q;
   assign cmd_q = qual[NUM_CMD-1:0];
   assign prog_q = qual[NUM_CMD];
   assign reset_q = qual[NUM_CMD+1];
   assign sel_q = qual[NUM_CMD+2];

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      hs_state_t st;
      logic [31:0] ctrl;
      logic [PROG_W-1:0] prog;
      logic [SEL_W-1:0] sel;
      logic reject;
      logic [IRQ_W-1:0] istat;
      logic [IRQ_W-1:0] ien;
      logic [NUM_CMD-1:0] cmd;
      logic shut;
      logic [31:0] rdata;
      logic ack;
      logic motor;
      logic home;
      logic power;
      logic calib;
   } core_t;

   core_t cur_ff;
   core_t nxt_cur;

   logic accept;
   logic [4:0] n_req;
   logic any_req;
   logic multi_req;
   logic shut_ok;
   logic [IRQ_W-1:0] ev;
   logic [ROBOTS-1:0] onehot_sel;

   // R02: remote acceptance window
   assign accept = (cur_ff.ctrl[CTRL_AUTO] & cur_ff.ctrl[CTRL_REMOTE])
                 | (cur_ff.ctrl[CTRL_PROGMODE] & cur_ff.ctrl[CTRL_RIO_EN]);

   always_comb begin
      n_req = 5'h00;
      for (int i = 0; i < NUM_CMD; i++) begin
         n_req = n_req + {4'h0, cmd_q[i]};
      end
      n_req = n_req + {4'h0, prog_q} + {4'h0, sel_q};
   end
   assign any_req = n_req != 5'h00;
   // R10: simultaneous requests
   assign multi_req = n_req > 5'h01;
   // R12: shutdown gated by ready
   assign shut_ok = ready_in;

   always_comb begin
      onehot_sel = '0;
      for (int i = 0; i < ROBOTS; i++) begin
         onehot_sel[i] = (cur_ff.sel == SEL_W'(i + 1));
      end
   end

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.cmd = '0;
      nxt_cur.shut = 1'b0;
      nxt_cur.ack = 1'b0;
      ev = '0;

      // R05: any motor on
      // R06: all robots home
      // R07: any high power
      // R08: any calibration missing
      // R04: zero selects all
      if (cur_ff.sel == SEL_ALL) begin
         nxt_cur.motor = |robot_motor_on;
         nxt_cur.home = &robot_at_home;
         nxt_cur.power = |robot_power_high;
         nxt_cur.calib = |robot_calib_missing;
      end else begin
         // R09: selected robot only
         nxt_cur.motor = |(robot_motor_on & onehot_sel);
         nxt_cur.home = |(robot_at_home & onehot_sel);
         nxt_cur.power = |(robot_power_high & onehot_sel);
         nxt_cur.calib = |(robot_calib_missing & onehot_sel);
      end

      case (cur_ff.st)
         ST_IDLE: begin
            if (any_req && accept) begin
               if (multi_req) begin
                  nxt_cur.st = ST_ERROR;
                  ev[IRQ_ERROR] = 1'b1;
               end else if (cmd_q[CMD_SHUTDOWN] && !shut_ok) begin
                  nxt_cur.reject = 1'b1;
                  ev[IRQ_REJECT] = 1'b1;
               end else if (sel_q) begin
                  // R16: selection held until changed
                  nxt_cur.sel = robot_select_code;
               end else begin
                  nxt_cur.reject = 1'b0;
                  nxt_cur.cmd = cmd_q;
                  nxt_cur.shut = cmd_q[CMD_SHUTDOWN];
                  if (prog_q) begin
                     nxt_cur.prog = cur_ff.ctrl[CTRL_PROG_LSB +: PROG_W];
                  end
                  nxt_cur.st = ST_RUN;
                  ev[IRQ_ACCEPT] = 1'b1;
                  ev[IRQ_SHUT] = cmd_q[CMD_SHUTDOWN];
               end
            end else if (any_req) begin
               // R17: refused command
               nxt_cur.reject = 1'b1;
               ev[IRQ_REJECT] = 1'b1;
            end
         end
         ST_RUN: begin
            if (any_req) begin
               nxt_cur.st = ST_ERROR;
               ev[IRQ_ERROR] = 1'b1;
            end
         end
         ST_ERROR: begin
            // R15: only reset honoured
            // R14: reset clears error
            if (reset_q) begin
               nxt_cur.st = ST_IDLE;
               nxt_cur.reject = 1'b0;
            end
         end
         default: begin
            nxt_cur.st = ST_IDLE;
         end
      endcase

      // Bus access; waitrequest drops one cycle after the request
      if ((avs_read || avs_write) && !cur_ff.ack) begin
         nxt_cur.ack = 1'b1;
         nxt_cur.rdata = 32'h00000000;
         if (avs_write) begin
            case (avs_address)
               REG_CTRL: begin
                  nxt_cur.ctrl = avs_writedata;
                  nxt_cur.ctrl[CTRL_ERR_SET] = 1'b0;
                  nxt_cur.ctrl[CTRL_PROG_LD] = 1'b0;
                  if (avs_writedata[CTRL_PROG_LD]) begin
                     nxt_cur.prog = avs_writedata[CTRL_PROG_LSB +: PROG_W];
                  end
                  // R13: software-raised fault latches
                  if (avs_writedata[CTRL_ERR_SET] && cur_ff.st != ST_ERROR) begin
                     nxt_cur.st = ST_ERROR;
                     ev[IRQ_ERROR] = 1'b1;
                  end
               end
               REG_IRQ_EN: nxt_cur.ien = avs_writedata[IRQ_W-1:0];
               REG_IRQ_CLR: nxt_cur.istat = cur_ff.istat & ~avs_writedata[IRQ_W-1:0];
               // R17: command finished
               REG_CMD_DONE: begin
                  if (cur_ff.st == ST_RUN && nxt_cur.st == ST_RUN) begin
                     nxt_cur.st = ST_IDLE;
                  end
               end
               default: begin
               end
            endcase
         end else begin
            case (avs_address)
               REG_CTRL: nxt_cur.rdata = cur_ff.ctrl;
               REG_STATUS: nxt_cur.rdata = {11'h000, cur_ff.sel, 5'h00, cur_ff.st,
                                            2'h0, cur_ff.prog};
               REG_IRQ_STAT: nxt_cur.rdata = {28'h0000000, cur_ff.istat};
               REG_IRQ_EN: nxt_cur.rdata = {28'h0000000, cur_ff.ien};
               REG_IRQ_CLR: nxt_cur.rdata = 32'h00000000;
               REG_CMD_DONE: nxt_cur.rdata = 32'h00000000;
               default: nxt_cur.rdata = DEAD_READ;
            endcase
         end
      end
      // Set wins over a same-cycle clear
      nxt_cur.istat = nxt_cur.istat | ev;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cur_ff <= '{st: ST_IDLE, ctrl: CTRL_RST, prog: PROG_RST, sel: SEL_ALL, default: '0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // R01: binary weighted program number
   assign {prog_num_bit5, prog_num_bit4, prog_num_bit3,
           prog_num_bit2, prog_num_bit1, prog_num_bit0} = cur_ff.prog;
   assign motor_energized_flag = cur_ff.motor;
   assign home_position_flag = cur_ff.home;
   assign high_power_flag = cur_ff.power;
   assign calib_needed_flag = cur_ff.calib;
   assign command_active_flag = cur_ff.st == ST_RUN;
   assign command_reject_flag = cur_ff.reject;
   assign remote_accept_flag = accept;
   assign error_flag = cur_ff.st == ST_ERROR;
   assign command_pulse = cur_ff.cmd;
   assign shutdown_pulse = cur_ff.shut;
   assign avs_readdata = cur_ff.rdata;
   assign avs_waitrequest = (avs_read | avs_write) & ~cur_ff.ack;
   assign irq = |(cur_ff.istat & cur_ff.ien);
endmodule : remote_io_handshake
`default_nettype wire

// file: verification/remote_io_checker.sv
// Port-level assertions for the remote handshake block
`timescale 1ns/1ps
`default_nettype none
module remote_io_checker
   import remote_io_pkg::*;
#(
   parameter int unsigned MIN_CYC = 8,
   parameter int unsigned ROBOTS = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Inputs watched
   input wire logic start_in,
   input wire logic error_reset_in,
   input wire logic ready_in,
   input wire logic [ROBOTS-1:0] robot_motor_on,
   input wire logic [ROBOTS-1:0] robot_at_home,
   input wire logic [ROBOTS-1:0] robot_power_high,
   input wire logic [ROBOTS-1:0] robot_calib_missing,
   // Outputs watched
   input wire logic motor_energized_flag,
   input wire logic home_position_flag,
   input wire logic high_power_flag,
   input wire logic calib_needed_flag,
   input wire logic command_active_flag,
   input wire logic remote_accept_flag,
   input wire logic error_flag,
   input wire logic [remote_io_pkg::NUM_CMD-1:0] command_pulse,
   input wire logic shutdown_pulse
);
   logic [CNT_W-1:0] run_ff;
   logic [CNT_W-1:0] nxt_run;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Saturates so a long hold never wraps; as wide as the qualifier count
   always_comb nxt_run = !start_in ? CNT_ZERO : (run_ff == {CNT_W{1'b1}} ? run_ff : run_ff + CNT_ONE);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) run_ff <= CNT_ZERO;
      else run_ff <= nxt_run;
   end
   a_start_width: assert property (command_pulse[0] |-> $past(run_ff) >= MIN_CYC)
      else $error("start accepted after a short pulse");
   a_pulse_single: assert property (command_pulse != 8'h00 |=> command_pulse == 8'h00)
      else $error("command pulse longer than one cycle");
   a_pulse_runs: assert property (command_pulse != 8'h00 |-> command_active_flag && $past(remote_accept_flag))
      else $error("command pulse without run or acceptance");
   a_error_holds: assert property (error_flag && !error_reset_in && !$past(error_reset_in) |=> error_flag)
      else $error("error output dropped without reset input");
   a_error_blocks: assert property (error_flag |-> command_pulse == 8'h00 && !command_active_flag)
      else $error("command executed during error");
   a_shut_ready: assert property (shutdown_pulse |-> command_pulse[7] && $past(ready_in))
      else $error("shutdown accepted while not ready");
   a_flags_any: assert property ((motor_energized_flag |-> $past(|robot_motor_on))
      and (high_power_flag |-> $past(|robot_power_high)))
      else $error("motor or power flag without any source robot");
   a_flags_home: assert property ((home_position_flag |-> $past(|robot_at_home))
      and (calib_needed_flag |-> $past(|robot_calib_missing)))
      else $error("home or calibration flag without source robot");
endmodule : remote_io_checker
bind remote_io_handshake remote_io_checker #(.MIN_CYC(MIN_CYC), .ROBOTS(ROBOTS)) chk (.clk, .reset_n,
   .start_in, .error_reset_in, .ready_in, .robot_motor_on, .robot_at_home, .robot_power_high, .robot_calib_missing,
   .motor_energized_flag, .home_position_flag, .high_power_flag, .calib_needed_flag, .command_active_flag,
   .remote_accept_flag, .error_flag, .command_pulse, .shutdown_pulse);
`default_nettype wire

// file: verification/plc_model.sv
// Behavioural external controller driving the remote command lines
`timescale 1ns/1ps
`default_nettype none
module plc_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Request from the bench
   input wire logic go,
   input wire logic [10:0] pick,
   input wire logic [7:0] len,
   // Command lines
   output logic [10:0] lines,
   output logic busy
);
   logic [7:0] left_ff;
   assign busy = left_ff != 8'h00;
   // lines as picked, held len edges
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         left_ff <= 8'h00;
         lines <= 11'h000;
      end else if (go) begin
         left_ff <= len;
         lines <= pick;
      end else if (busy) begin
         left_ff <= left_ff - 8'h01;
         if (left_ff == 8'h01) lines <= 11'h000;
      end
   end
endmodule : plc_model
`default_nettype wire

// file: verification/tb_remote_io_handshake.sv
// Self-checking bench for the remote handshake block
`timescale 1ns/1ps
`default_nettype none
module tb_remote_io_handshake;
   import remote_io_pkg::*;
   localparam int unsigned MINC = 8;
   localparam int unsigned SETTLE = 16;
   typedef struct {logic [4:0] sel; logic [15:0] m; logic [15:0] h; logic [15:0] p; logic [15:0] c; logic [3:0] f;} row_t;
   row_t rows [6] = '{'{5'h00, 16'h0001, 16'hFFFF, 16'h0000, 16'h0000, 4'hC},
      '{5'h00, 16'h0000, 16'h7FFF, 16'h8000, 16'h0100, 4'h3}, '{5'h10, 16'h8000, 16'h8000, 16'h7FFF, 16'h0000, 4'hC},
      '{5'h10, 16'h7FFF, 16'h7FFF, 16'h8000, 16'h8000, 4'h3}, '{5'h01, 16'h0001, 16'h0000, 16'h0000, 16'h0001, 4'h9},
      '{5'h11, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 4'h0}};
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, irq, busy, ready_in = 1'b1, go = 1'b0;
   logic [10:0] pick = '0;
   logic [10:0] lines;
   logic [7:0] len = '0;
   logic [7:0] got, command_pulse;
   logic [4:0] robot_select_code = '0;
   logic [15:0] robot_motor_on = '0, robot_at_home = '0, robot_power_high = '0, robot_calib_missing = '0;
   logic [5:0] prog;
   logic motor_energized_flag, home_position_flag, high_power_flag, calib_needed_flag, shutdown_pulse, shut_got;
   logic command_active_flag, command_reject_flag, remote_accept_flag, error_flag;
   int err_count = 0;
   int check_count = 0;
   always #25 clk = ~clk;
   plc_model plc (.clk, .reset_n, .go, .pick, .len, .lines, .busy);
   remote_io_handshake #(.MIN_CYC(MINC), .ROBOTS(16)) dut (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .program_select_in(lines[8]), .start_in(lines[0]),
      .stop_in(lines[1]), .pause_in(lines[2]), .continue_in(lines[3]), .energize_motors_in(lines[4]),
      .power_up_request_in(lines[5]), .power_down_request_in(lines[6]), .shutdown_in(lines[7]),
      .error_reset_in(lines[9]), .robot_select_strobe_in(lines[10]), .robot_select_code, .robot_motor_on,
      .robot_at_home, .robot_power_high, .robot_calib_missing, .ready_in, .prog_num_bit0(prog[0]),
      .prog_num_bit1(prog[1]), .prog_num_bit2(prog[2]), .prog_num_bit3(prog[3]), .prog_num_bit4(prog[4]),
      .prog_num_bit5(prog[5]), .motor_energized_flag, .home_position_flag, .high_power_flag, .calib_needed_flag,
      .command_active_flag, .command_reject_flag, .remote_accept_flag, .error_flag, .command_pulse, .shutdown_pulse);
   task automatic tally_and_finish();
      $display("Checks made: %0d, mismatches: %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   // Waitrequest and read data are taken at the rising edge, before that edge updates the slave
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      if (n >= 20) begin
         err_count++;
         tally_and_finish();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic cmd(input logic [10:0] p, input logic [7:0] l);
      got = '0;
      shut_got = 1'b0;
      @(posedge clk);
      pick <= p;
      len <= l;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (int'(l) + 4) begin
         @(negedge clk);
         got = got | command_pulse;
         shut_got = shut_got | shutdown_pulse;
      end
   endtask : cmd
   initial begin
      logic [5:0] v;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      bus(1'b1, REG_CTRL, 32'h00000003);
      check(32'(remote_accept_flag), 32'h1);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         robot_select_code <= rows[i].sel;
         cmd(11'h400, 8'h0A);
         bus(1'b1, REG_CMD_DONE, 32'h0);
         repeat (SETTLE) @(posedge clk);
         robot_motor_on <= rows[i].m;
         robot_at_home <= rows[i].h;
         robot_power_high <= rows[i].p;
         robot_calib_missing <= rows[i].c;
         repeat (3) @(negedge clk);
         check(32'({motor_energized_flag, home_position_flag, high_power_flag, calib_needed_flag}), 32'(rows[i].f));
      end
      bus(1'b0, REG_STATUS, 32'h0);
      check(q, 32'h00110100);
      for (int i = 0; i < 7; i++) begin
         cmd(11'(1 << i), 8'h0A);
         check(32'({got, command_active_flag, command_reject_flag}), 32'({8'(1 << i), 2'b10}));
         bus(1'b1, REG_CMD_DONE, 32'h0);
      end
      bus(1'b1, REG_CTRL, 32'h0);
      cmd(11'h001, 8'h0A);
      check(32'({got, command_reject_flag, remote_accept_flag, command_active_flag}), 32'h004);
      for (int k = 0; k < 2; k++) begin
         v = (k == 0) ? 6'h2D : 6'h3F;
         bus(1'b1, REG_CTRL, 32'h0000000C | (32'(v) << 8));
         cmd(11'h100, 8'h0A);
         check(32'({prog, remote_accept_flag}), 32'({v, 1'b1}));
         bus(1'b1, REG_CMD_DONE, 32'h0);
      end
      cmd(11'h001, 8'(MINC - 1));
      check(32'({got, command_active_flag}), 32'h0);
      cmd(11'h001, 8'(MINC));
      check(32'({got, command_active_flag}), 32'h3);
      bus(1'b1, REG_CMD_DONE, 32'h0);
      @(posedge clk);
      ready_in <= 1'b0;
      cmd(11'h080, 8'h0A);
      check(32'({got, command_reject_flag, shut_got}), 32'h002);
      @(posedge clk);
      ready_in <= 1'b1;
      cmd(11'h080, 8'h0A);
      check(32'({got, command_reject_flag, shut_got}), 32'h201);
      bus(1'b1, REG_CMD_DONE, 32'h0);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      check(q, 32'h0000000E);
      bus(1'b1, REG_IRQ_CLR, 32'h0000000F);
      bus(1'b1, REG_IRQ_EN, 32'h0);
      cmd(11'h001, 8'h0A);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      check({q[30:0], irq}, 32'h00000008);
      bus(1'b1, REG_IRQ_EN, 32'h00000004);
      repeat (2) @(negedge clk);
      check(32'(irq), 32'h1);
      bus(1'b1, REG_IRQ_CLR, 32'h00000004);
      repeat (2) @(negedge clk);
      check(32'(irq), 32'h0);
      bus(1'b1, REG_CMD_DONE, 32'h0);
      cmd(11'h003, 8'h0A);
      check(32'({got, error_flag}), 32'h1);
      cmd(11'h001, 8'h0A);
      check(32'({got, error_flag, command_active_flag}), 32'h2);
      cmd(11'h200, 8'h0A);
      check(32'(error_flag), 32'h0);
      cmd(11'h001, 8'h0A);
      cmd(11'h002, 8'h0A);
      check(32'({got, error_flag}), 32'h1);
      cmd(11'h200, 8'h0A);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      bus(1'b0, REG_STATUS, 32'h0);
      check(q, 32'h00000100);
      check(32'({prog, motor_energized_flag, home_position_flag, high_power_flag, calib_needed_flag}), 32'hF);
      bus(1'b0, 4'h6, 32'h0);
      check(q, DEAD_READ);
      // Software-raised fault and immediate program load in one write
      bus(1'b1, REG_CTRL, 32'h00009F13);
      check(32'({prog, error_flag}), 32'h3F);
      bus(1'b0, REG_CTRL, 32'h0);
      check(q, 32'h00001F03);
      bus(1'b0, REG_IRQ_STAT, 32'h0);
      check(q, 32'h00000001);
      cmd(11'h200, 8'h0A);
      check(32'(error_flag), 32'h0);
      tally_and_finish();
   end
endmodule : tb_remote_io_handshake
`default_nettype wire
